/* bench/rirq_spi_host.sv */
`timescale 1ns/1ns
// ************************************************
// serial master model, 3-wire link
// ************************************************
module rirq_spi_host (
   // clock
   input  wire logic pclk,
   // link pins
   input  wire logic mosi_wire,
   output logic      sck,
   output logic      ss_n,
   output logic      mosi_o,
   output logic      mosi_oe
);
   // idle: clock parked low, line released
   initial begin
      sck = 1'h0;
      ss_n = 1'h1;
      mosi_o = 1'h0;
      mosi_oe = 1'h0;
   end
   // select well before the first clock rise
   task automatic open_frame();
      @(posedge pclk);
      ss_n <= 1'h0;
      repeat (3) @(posedge pclk);
   endtask
   // line stays released while deselected
   task automatic close_frame();
      repeat (3) @(posedge pclk);
      ss_n <= 1'h1;
   endtask
   // msb first, line driven only while sending
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         mosi_oe <= 1'h1;
         mosi_o  <= b[i];
         repeat (3) @(posedge pclk);
         sck <= 1'h1;
         repeat (3) @(posedge pclk);
         sck <= 1'h0;
      end
      mosi_oe <= 1'h0;
      // three edges pass before a following send raises it again
      repeat (3) @(posedge pclk);
   endtask
   // sample the shared line just before each rise
   task automatic recv(output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         repeat (3) @(posedge pclk);
         b[i] = mosi_wire;
         sck <= 1'h1;
         repeat (3) @(posedge pclk);
         sck <= 1'h0;
      end
   endtask
endmodule // rirq_spi_host

/* bench/rirq_top_tb.sv */
`timescale 1ns/1ns
module rirq_top_tb;
   // ************************************************
   // signals
   // ************************************************
   logic                 pclk, presetn, ce, psel, penable, pwrite;
   logic                 pready, pslverr, sop, agc_lna, xtal;
   logic [7:0]           paddr, q;
   logic [31:0]          pwdata, prdata;
   logic [4:0]           level;
   rirq_pkg::rirq_mode_e mode;
   rirq_pkg::rirq_evt_s  evt;
   logic                 agc_on, gain_lna, gain_damp, clk_out, e;
   logic                 irq_out, irq_oe, sck, ss_n, mosi_out, mosi_oe;
   logic                 h_o, h_oe, mlast, mosi_w;
   int                   n_errors, num_checks, edges, n;
   // released line shows the inverse of its last level, no pull
   assign mosi_w = mosi_oe ? mosi_out : (h_oe ? h_o : ~mlast);
   always @(posedge pclk) mlast <= mosi_w;
   always #2 pclk = ~pclk;
   // near-12 MHz reference; odd ns edges stay off the pclk rise
   initial begin
      #1;
      forever #42 xtal = ~xtal;
   end
   always @(posedge clk_out) edges++;
   rirq_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .radio_mode(mode), .evt(evt), .sop_detect(sop), .level_in(level),
      .agc_lna(agc_lna), .xtal_ref(xtal), .agc_on(agc_on),
      .gain_lna(gain_lna), .gain_damp(gain_damp), .clk_out(clk_out),
      .irq_out(irq_out), .irq_oe(irq_oe), .spi_sck(sck), .spi_ss_n(ss_n),
      .mosi_in(mosi_w), .mosi_out(mosi_out), .mosi_oe(mosi_oe));
   rirq_spi_host host_u (.pclk(pclk), .mosi_wire(mosi_w), .sck(sck),
      .ss_n(ss_n), .mosi_o(h_o), .mosi_oe(h_oe));
   // ************************************************
   // helpers
   // ************************************************
   task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
      num_checks++;
      if (g !== x) begin
         n_errors++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, g);
      end
   endtask
   // one apb transfer, held until pready is seen at an edge
   task automatic apb(logic w, logic [7:0] a, logic [7:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'h1 && k < 50);
      if (k >= 50) chk("pready", 1, 0);
      q = prdata[7:0];
      e = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask
   task automatic wr(logic [5:0] i, logic [7:0] d);
      apb(1'h1, {i, 2'h0}, d);
   endtask
   task automatic rd(logic [5:0] i, string nm, logic [7:0] x);
      apb(1'h0, {i, 2'h0}, 8'h00);
      chk(nm, x, q);
   endtask
   // one-cycle event pulse, then let the pin settle
   task automatic fire(rirq_pkg::rirq_evt_s v);
      @(posedge pclk);
      evt <= v;
      @(posedge pclk);
      evt <= '0;
      repeat (3) @(posedge pclk);
   endtask
   task automatic set_mode(rirq_pkg::rirq_mode_e m);
      mode <= m;
      repeat (3) @(posedge pclk);
   endtask
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // hang guard, nearly six times the expected run
   initial begin
      #400000;
      n_errors++;
      conclude();
   end
   // ************************************************
   // tests
   // ************************************************
   initial begin
      pclk = 1'h0; presetn = 1'h0; ce = 1'h1; psel = 1'h0; penable = 1'h0;
      pwrite = 1'h0; paddr = 8'h00; pwdata = 32'h0; sop = 1'h0; xtal = 1'h0;
      agc_lna = 1'h0; level = 5'h00; evt = '0; mode = rirq_pkg::M_IDLE;
      mlast = 1'h0; n_errors = 0; num_checks = 0; edges = 0;
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      rd(rirq_pkg::A_IRQ_CFG, "irq_cfg", rirq_pkg::IRQ_CFG_RST);
      rd(rirq_pkg::A_RX_CFG, "rx_cfg", rirq_pkg::RX_CFG_RST);
      rd(rirq_pkg::A_LINK, "link", rirq_pkg::LINK_RST);
      chk("gain_lna", 1, gain_lna);
      apb(1'h0, 8'h80, 8'h00);
      chk("unmapped_err", 1, e);
      apb(1'h0, 8'h09, 8'h00);
      chk("misaligned_err", 1, e);
      // clock out: every rate, then stopped
      for (int s = 0; s <= 4; s++) begin
         wr(rirq_pkg::A_CLK_CFG, 8'(s));
         repeat (20) @(posedge pclk);
         edges = 0;
         repeat (2000) @(posedge pclk);
         n = 96 >> s;
         chk("clk_edges", n, (edges >= n - 2 && edges <= n + 2) ? n : edges);
      end
      wr(rirq_pkg::A_CLK_CFG, 8'h08);
      edges = 0;
      repeat (500) @(posedge pclk);
      chk("clk_off", 0, edges);
      // auto gain follows the core, then manual gain and damping
      wr(rirq_pkg::A_RX_CFG, 8'h03);
      repeat (2) @(posedge pclk);
      chk("gain_auto", 32'h1, {gain_lna, gain_damp, agc_on});
      wr(rirq_pkg::A_RX_CFG, 8'h04);
      repeat (2) @(posedge pclk);
      chk("gain", 32'h2, {gain_lna, gain_damp, agc_on});
      // irq: enable, mode muting, status, polarity, driver
      wr(rirq_pkg::A_TX_EN, 8'h01);
      fire('{tx: 8'h01, rx: 8'h00, sys: 8'h00});
      chk("irq_tx", 0, irq_out);
      rd(rirq_pkg::A_TX_ST, "tx_st", 8'h01);
      set_mode(rirq_pkg::M_RX);
      chk("irq_rx_mute", 1, irq_out);
      rd(rirq_pkg::A_TX_EN, "tx_en_kept", 8'h01);
      set_mode(rirq_pkg::M_TX);
      chk("irq_tx_mode", 0, irq_out);
      wr(rirq_pkg::A_TX_ST, 8'h01);
      repeat (3) @(posedge pclk);
      chk("irq_cleared", 1, irq_out);
      fire('{tx: 8'h00, rx: 8'h04, sys: 8'h00});
      rd(rirq_pkg::A_RX_ST, "rx_st", 8'h04);
      wr(rirq_pkg::A_RX_EN, 8'h04);
      repeat (3) @(posedge pclk);
      chk("irq_rx_muted", 1, irq_out);
      set_mode(rirq_pkg::M_IDLE);
      chk("irq_rx", 0, irq_out);
      wr(rirq_pkg::A_IRQ_CFG, 8'h01);
      repeat (3) @(posedge pclk);
      chk("irq_high", 1, irq_out);
      wr(rirq_pkg::A_IRQ_CFG, 8'h02);
      repeat (3) @(posedge pclk);
      chk("od_active", 32'h1, {irq_out, irq_oe});
      wr(rirq_pkg::A_RX_ST, 8'h04);
      repeat (3) @(posedge pclk);
      chk("od_idle", 0, irq_oe);
      wr(rirq_pkg::A_IRQ_CFG, 8'h00);
      wr(rirq_pkg::A_SYS_EN, 8'h80);
      set_mode(rirq_pkg::M_RX);
      fire('{tx: 8'h00, rx: 8'h00, sys: 8'h80});
      chk("irq_sys", 0, irq_out);
      // irq on the data line only while deselected
      wr(rirq_pkg::A_LINK, 8'h40);
      repeat (3) @(posedge pclk);
      chk("mux_drive", 32'h2, {mosi_oe, mosi_out});
      host_u.open_frame();
      chk("mux_off", 0, mosi_oe);
      host_u.close_frame();
      wr(rirq_pkg::A_SYS_ST, 8'h80);
      wr(rirq_pkg::A_LINK, 8'h00);
      // serial writes: stepping and fixed-address bursts
      host_u.open_frame();
      host_u.send({2'h3, rirq_pkg::A_IRQ_CFG});
      host_u.send(8'h00);
      host_u.send(8'h33);
      host_u.close_frame();
      host_u.open_frame();
      host_u.send({2'h2, rirq_pkg::A_RX_EN});
      host_u.send(8'h44);
      host_u.send(8'h55);
      host_u.close_frame();
      rd(rirq_pkg::A_TX_EN, "step_wr", 8'h33);
      rd(rirq_pkg::A_RX_EN, "fixed_wr", 8'h55);
      // serial read with the line turned round after the header
      host_u.open_frame();
      host_u.send({2'h0, rirq_pkg::A_TX_EN});
      wr(rirq_pkg::A_LINK, 8'h80);
      host_u.recv(q);
      chk("spi_read", 8'h33, q);
      host_u.close_frame();
      wr(rirq_pkg::A_LINK, 8'h00);
      // level: packet start sample, read retrigger, spacing
      wr(rirq_pkg::A_RX_CFG, 8'h0A);
      level <= 5'h13;
      @(posedge pclk);
      sop <= 1'h1;
      @(posedge pclk);
      sop <= 1'h0;
      // capture lands one edge after the pulse, hold the value
      @(posedge pclk);
      level <= 5'h07;
      rd(rirq_pkg::A_LEVEL, "lvl_sop", 8'h13);
      repeat (3100) @(posedge pclk);
      rd(rirq_pkg::A_LEVEL, "lvl_retrig", 8'h07);
      level <= 5'h1F;
      rd(rirq_pkg::A_LEVEL, "lvl_same", 8'h07);
      level <= 5'h0A;
      rd(rirq_pkg::A_LEVEL, "lvl_gap", 8'h07);
      repeat (3100) @(posedge pclk);
      rd(rirq_pkg::A_LEVEL, "lvl_late", 8'h0A);
      conclude();
   end
endmodule // rirq_top_tb

/* inc/rirq_pkg.sv */
// How it works
// [R1] irq polarity and driver type programmable
// [R2] tx, rx, system sets enabled, one pin
// [R3] tx mode mutes rx, rx mode mutes tx
// [R4] mode muting leaves enable bits untouched
// [R5] status records events regardless of enable
// [R6] host reads status to find the cause
// [R7] clock out 12, 6, 3, 1.5 or 0.75 MHz
// [R8] clock out on after reset, can stop
// [R9] manual gain follows the amplifier bit
// [R10] damping bit adds further attenuation
// [R11] host should prefer manual gain, amp on
// [R12] level reading stored as 5 bits
// [R13] level sampled on packet start
// [R14] level read retriggers, 12 us spacing
// [R15] serial clock from master, one data line
// [R16] master floats data line unless sending
// [R17] master flips line direction via bit 7
// [R18] master selects slave before any transfer
// [R19] muxed irq on data line only deselected
// [R20] master floats data line while deselected
// [R21] header: direction, stepping, 6-bit address
// [R22] stepping advances address per data byte
// [R23] irq when enabled unmuted status is set
// [R24] serial access needs no radio oscillator
package rirq_pkg;
   // ************************************************
   // register indices, byte address is four times
   // ************************************************
   localparam logic [5:0] A_IRQ_CFG = 6'h01;
   localparam logic [5:0] A_TX_EN   = 6'h02;
   localparam logic [5:0] A_TX_ST   = 6'h03;
   localparam logic [5:0] A_RX_EN   = 6'h04;
   localparam logic [5:0] A_RX_ST   = 6'h05;
   localparam logic [5:0] A_SYS_EN  = 6'h06;
   localparam logic [5:0] A_SYS_ST  = 6'h07;
   localparam logic [5:0] A_RX_CFG  = 6'h08;
   localparam logic [5:0] A_LEVEL   = 6'h09;
   localparam logic [5:0] A_CLK_CFG = 6'h0A;
   localparam logic [5:0] A_LINK    = 6'h3D;
   // ************************************************
   // field positions and reset values
   // ************************************************
   localparam int B_POL = 0;
   localparam int B_OD = 1;
   localparam int B_AGC = 0;
   localparam int B_LNA = 1;
   localparam int B_DAMP = 2;
   localparam int B_MEAS = 3;
   localparam int B_CLK_OFF = 3;
   localparam int B_TURN = 7;
   localparam int B_IRQMUX = 6;
   localparam int H_DIR = 7;
   localparam int H_INC = 6;
   localparam logic [2:0] CLK_SEL_MAX = 3'h4;
   localparam logic [7:0] IRQ_CFG_RST = 8'h00;
   localparam logic [7:0] RX_CFG_RST = 8'h02;
   localparam logic [7:0] CLK_CFG_RST = 8'h00;
   localparam logic [7:0] LINK_RST = 8'h00;
   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_NS = 4;
   localparam int MEAS_GAP_NS = 12000;
   localparam logic [11:0] MEAS_GAP_CYC =
      12'((MEAS_GAP_NS + CLK_NS - 1) / CLK_NS);
   // ************************************************
   // types
   // ************************************************
   typedef enum logic [1:0] {
      M_IDLE, M_TX, M_RX
   } rirq_mode_e;
   typedef enum logic [1:0] {
      S_IDLE, S_HEAD, S_DATA
   } rirq_spi_e;
   typedef struct packed {
      logic [7:0] tx;
      logic [7:0] rx;
      logic [7:0] sys;
   } rirq_evt_s;
endpackage

/* rtl/rirq_top.sv */
`timescale 1ns/1ns
module rirq_top (
   // clock, reset, freeze
   input  wire logic             pclk,
   input  wire logic             presetn,
   input  wire logic             ce,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic                  pready,
   output logic [31:0]           prdata,
   output logic                  pslverr,
   // radio core side
   input  wire rirq_pkg::rirq_mode_e radio_mode,
   input  wire rirq_pkg::rirq_evt_s  evt,
   input  wire logic             sop_detect,
   input  wire logic [4:0]       level_in,
   input  wire logic             agc_lna,
   input  wire logic             xtal_ref,
   output logic                  agc_on,
   output logic                  gain_lna,
   output logic                  gain_damp,
   output logic                  clk_out,
   // interrupt pin
   output logic                  irq_out,
   output logic                  irq_oe,
   // serial link
   input  wire logic             spi_sck,
   input  wire logic             spi_ss_n,
   input  wire logic             mosi_in,
   output logic                  mosi_out,
   output logic                  mosi_oe
);
   // ************************************************
   // state
   // ************************************************
   logic [7:0]          irq_cfg_q, rx_cfg_q, clk_cfg_q, link_q;
   logic [7:0]          tx_en_q, rx_en_q, sys_en_q;
   logic [7:0]          tx_st_q, rx_st_q, sys_st_q;
   logic [4:0]          level_q;
   logic [11:0]         gap_q;
   logic                meas_req_q;
   logic [3:0]          div_q;
   logic                xtal_q;
   logic                sck_q;
   rirq_pkg::rirq_spi_e sp_q;
   logic [2:0]          bit_q;
   logic [7:0]          rx_sh_q, tx_sh_q;
   logic [5:0]          sp_addr_q;
   logic                sp_dir_q, sp_inc_q;
   logic                spw_q;
   logic [5:0]          spw_a_q;
   logic [7:0]          spw_d_q;
   logic                apb_fire, apb_wr, apb_rd;
   logic                wr_en;
   logic [5:0]          wr_a;
   logic [7:0]          wr_d;
   logic                rise, fall, byte_done;
   logic [7:0]          byte_in;
   logic [5:0]          nxt_a;
   logic                lvl_rd, sop_trig, cap;
   logic [7:0]          tx_on, rx_on;
   logic                irq_act;

   // ************************************************
   // register read and decode helpers
   // ************************************************
   function automatic logic [7:0] reg_rd(input logic [5:0] a);
      logic [7:0] r;
      r = 8'h00;
      unique case (a)
         rirq_pkg::A_IRQ_CFG: r = irq_cfg_q;
         rirq_pkg::A_TX_EN:   r = tx_en_q;
         rirq_pkg::A_TX_ST:   r = tx_st_q;
         rirq_pkg::A_RX_EN:   r = rx_en_q;
         rirq_pkg::A_RX_ST:   r = rx_st_q;
         rirq_pkg::A_SYS_EN:  r = sys_en_q;
         rirq_pkg::A_SYS_ST:  r = sys_st_q;
         rirq_pkg::A_RX_CFG:  r = rx_cfg_q;
         rirq_pkg::A_LEVEL:   r = {3'h0, level_q}; // R12
         rirq_pkg::A_CLK_CFG: r = clk_cfg_q;
         rirq_pkg::A_LINK:    r = link_q;
         default:             r = 8'h00;
      endcase
      return r;
   endfunction

   function automatic logic mapped(input logic [5:0] a);
      return (a >= rirq_pkg::A_IRQ_CFG && a <= rirq_pkg::A_CLK_CFG)
         || a == rirq_pkg::A_LINK;
   endfunction

   // ************************************************
   // apb slave
   // ************************************************
   // one wait state: ready rises in the second access cycle
   assign apb_fire = psel & penable & pready;
   assign apb_wr = apb_fire & pwrite & ~pslverr;
   assign apb_rd = apb_fire & ~pwrite;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (ce) begin
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready
            & (paddr[1:0] != 2'h0 | ~mapped(paddr[7:2]));
         if (psel & penable & ~pready)
            prdata <= {24'h00_0000, reg_rd(paddr[7:2])};
      end
   end

   // apb wins a collision; a serial write waits one cycle
   assign wr_en = apb_wr | spw_q;
   assign wr_a = apb_wr ? paddr[7:2] : spw_a_q;
   assign wr_d = apb_wr ? pwdata[7:0] : spw_d_q;

   // ************************************************
   // configuration and enable registers
   // ************************************************
   // enables change only by writes, never by the mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_cfg_q <= rirq_pkg::IRQ_CFG_RST;
         rx_cfg_q  <= rirq_pkg::RX_CFG_RST;
         clk_cfg_q <= rirq_pkg::CLK_CFG_RST; // R8
         link_q    <= rirq_pkg::LINK_RST;
         tx_en_q   <= 8'h00;
         rx_en_q   <= 8'h00;
         sys_en_q  <= 8'h00;
      end else if (ce && wr_en) begin // R4
         unique case (wr_a)
            rirq_pkg::A_IRQ_CFG: irq_cfg_q <= wr_d; // R1
            rirq_pkg::A_TX_EN:   tx_en_q <= wr_d; // R2
            rirq_pkg::A_RX_EN:   rx_en_q <= wr_d; // R2
            rirq_pkg::A_SYS_EN:  sys_en_q <= wr_d; // R2
            rirq_pkg::A_RX_CFG:  rx_cfg_q <= wr_d;
            rirq_pkg::A_CLK_CFG: clk_cfg_q <= wr_d;
            rirq_pkg::A_LINK:    link_q <= wr_d; // R17
            default: ;
         endcase
      end
   end

   // ************************************************
   // status: sticky, write one to clear, set wins
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_q  <= 8'h00;
         rx_st_q  <= 8'h00;
         sys_st_q <= 8'h00;
      end else if (ce) begin
         tx_st_q <= (tx_st_q & ~((wr_en && wr_a == rirq_pkg::A_TX_ST)
            ? wr_d : 8'h00)) | evt.tx; // R5
         rx_st_q <= (rx_st_q & ~((wr_en && wr_a == rirq_pkg::A_RX_ST)
            ? wr_d : 8'h00)) | evt.rx; // R5
         sys_st_q <= (sys_st_q & ~((wr_en && wr_a == rirq_pkg::A_SYS_ST)
            ? wr_d : 8'h00)) | evt.sys; // R5
      end
   end

   chk_status_set: assert property (@(posedge pclk) disable iff (!presetn)
      ce && evt.tx != 8'h00 |=> (tx_st_q & $past(evt.tx)) == $past(evt.tx))
      else $error("tx event not recorded in status"); // R5

   // ************************************************
   // interrupt request
   // ************************************************
   // muting acts on the gates only, so enables survive
   assign tx_on = radio_mode == rirq_pkg::M_RX ? 8'h00 : tx_en_q; // R3
   assign rx_on = radio_mode == rirq_pkg::M_TX ? 8'h00 : rx_en_q; // R3
   assign irq_act = |(tx_st_q & tx_on) | |(rx_st_q & rx_on)
      | |(sys_st_q & sys_en_q); // R23

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_out <= 1'b1;
         irq_oe  <= 1'b1;
      end else if (ce) begin
         irq_out <= irq_act ~^ irq_cfg_q[rirq_pkg::B_POL]; // R1
         // open drain drives only the low level
         irq_oe <= ~irq_cfg_q[rirq_pkg::B_OD]
            | ~(irq_act ~^ irq_cfg_q[rirq_pkg::B_POL]); // R1
      end
   end

   chk_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
      ce |=> irq_out == ($past(irq_act) ~^ $past(irq_cfg_q[0])))
      else $error("irq level does not follow status and polarity"); // R23

   chk_rx_muted: assert property (@(posedge pclk) disable iff (!presetn)
      ce && radio_mode == rirq_pkg::M_TX && (tx_st_q & tx_en_q) == 8'h00
      && (sys_st_q & sys_en_q) == 8'h00 |=> irq_out == ~$past(irq_cfg_q[0]))
      else $error("rx source raised irq in transmit mode"); // R3

   chk_en_kept: assert property (@(posedge pclk) disable iff (!presetn)
      radio_mode != $past(radio_mode) && !wr_en |=> $stable(rx_en_q)
      && $stable(tx_en_q))
      else $error("enable changed on mode switch"); // R4

   // ************************************************
   // gain control
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         agc_on    <= 1'b0;
         gain_lna  <= 1'b1;
         gain_damp <= 1'b0;
      end else if (ce) begin
         agc_on   <= rx_cfg_q[rirq_pkg::B_AGC];
         gain_lna <= rx_cfg_q[rirq_pkg::B_AGC] ? agc_lna
            : rx_cfg_q[rirq_pkg::B_LNA]; // R9
         gain_damp <= rx_cfg_q[rirq_pkg::B_DAMP]; // R10
      end
   end

   chk_gain_manual: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !rx_cfg_q[0] |=> gain_lna == $past(rx_cfg_q[1]))
      else $error("manual gain ignores amplifier bit"); // R9

   // ************************************************
   // level measurement
   // ************************************************
   // reads of the level register from either port retrigger
   assign lvl_rd = (apb_rd && paddr[7:2] == rirq_pkg::A_LEVEL)
      || (rise && byte_done && sp_q != rirq_pkg::S_IDLE
          && !(sp_q == rirq_pkg::S_HEAD ? byte_in[rirq_pkg::H_DIR]
               : sp_dir_q)
          && nxt_a == rirq_pkg::A_LEVEL); // R14
   assign sop_trig = sop_detect && radio_mode == rirq_pkg::M_RX; // R13
   assign cap = meas_req_q && gap_q == 12'h000
      && rx_cfg_q[rirq_pkg::B_MEAS];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meas_req_q <= 1'b0;
         gap_q      <= 12'h000;
         level_q    <= 5'h00;
      end else if (ce) begin
         meas_req_q <= (meas_req_q & ~cap)
            | (rx_cfg_q[rirq_pkg::B_MEAS] & (sop_trig | lvl_rd)); // R13
         if (cap) begin
            level_q <= level_in; // R12
            gap_q   <= rirq_pkg::MEAS_GAP_CYC - 12'h001; // R14
         end else if (gap_q != 12'h000) begin
            gap_q <= gap_q - 12'h001;
         end
      end
   end

   chk_meas_gap: assert property (@(posedge pclk) disable iff (!presetn)
      ce && cap |=> gap_q == rirq_pkg::MEAS_GAP_CYC - 12'h001 ##1 !cap [*8])
      else $error("level samples spaced too closely"); // R14

   // ************************************************
   // clock output divider
   // ************************************************
   // the 12 MHz reference is sampled, so pclk must be fast
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xtal_q  <= 1'b0;
         div_q   <= 4'h0;
         clk_out <= 1'b0;
      end else if (ce) begin
         xtal_q <= xtal_ref;
         if (xtal_ref && !xtal_q)
            div_q <= div_q + 4'h1;
         if (clk_cfg_q[rirq_pkg::B_CLK_OFF])
            clk_out <= 1'b0; // R8
         else if (clk_cfg_q[2:0] == 3'h0)
            clk_out <= xtal_ref; // R7
         else if (clk_cfg_q[2:0] <= rirq_pkg::CLK_SEL_MAX)
            clk_out <= div_q[2'(clk_cfg_q[2:0] - 3'h1)]; // R7
         else
            clk_out <= div_q[3]; // R7
      end
   end

   chk_clk_off: assert property (@(posedge pclk) disable iff (!presetn)
      ce && clk_cfg_q[3] |=> !clk_out)
      else $error("clock output running while disabled"); // R8

   // ************************************************
   // serial link slave, mode 0, msb first
   // ************************************************
   // runs on the bus clock only, never the radio oscillator
   assign rise = spi_sck && !sck_q && !spi_ss_n; // R24
   assign fall = !spi_sck && sck_q && !spi_ss_n;
   assign byte_done = bit_q == 3'h7;
   assign byte_in = {rx_sh_q[6:0], mosi_in};
   assign nxt_a = sp_q == rirq_pkg::S_HEAD ? byte_in[5:0]
      : (sp_inc_q ? sp_addr_q + 6'h01 : sp_addr_q); // R22

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sck_q     <= 1'b0;
         sp_q      <= rirq_pkg::S_IDLE;
         bit_q     <= 3'h0;
         rx_sh_q   <= 8'h00;
         tx_sh_q   <= 8'h00;
         sp_addr_q <= 6'h00;
         sp_dir_q  <= 1'b0;
         sp_inc_q  <= 1'b0;
      end else if (ce) begin
         sck_q <= spi_sck; // R15
         if (spi_ss_n) begin
            sp_q  <= rirq_pkg::S_IDLE;
            bit_q <= 3'h0;
         end else if (rise) begin
            rx_sh_q <= byte_in;
            bit_q   <= bit_q + 3'h1;
            if (sp_q == rirq_pkg::S_IDLE)
               sp_q <= rirq_pkg::S_HEAD;
            if (byte_done) begin
               unique case (sp_q)
                  rirq_pkg::S_IDLE, rirq_pkg::S_HEAD: begin
                     sp_dir_q <= byte_in[rirq_pkg::H_DIR]; // R21
                     sp_inc_q <= byte_in[rirq_pkg::H_INC]; // R21
                     sp_addr_q <= byte_in[5:0]; // R21
                     sp_q <= rirq_pkg::S_DATA;
                  end
                  rirq_pkg::S_DATA: sp_addr_q <= nxt_a; // R22
               endcase
               tx_sh_q <= reg_rd(nxt_a);
            end
         end else if (fall && bit_q != 3'h0) begin
            // no shift right after a load, msb must survive
            tx_sh_q <= {tx_sh_q[6:0], 1'b0};
         end
      end
   end

   // a finished write byte is held until the apb path is free
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         spw_q   <= 1'b0;
         spw_a_q <= 6'h00;
         spw_d_q <= 8'h00;
      end else if (ce) begin
         if (rise && byte_done && sp_q == rirq_pkg::S_DATA && sp_dir_q)
         begin
            spw_q   <= 1'b1;
            spw_a_q <= sp_addr_q; // R22
            spw_d_q <= byte_in;
         end else if (!apb_wr) begin
            spw_q <= 1'b0;
         end
      end
   end

   // ************************************************
   // shared data line, turnaround and irq multiplex
   // ************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mosi_out <= 1'b0;
         mosi_oe  <= 1'b0;
      end else if (ce) begin
         if (!spi_ss_n) begin
            mosi_out <= tx_sh_q[7];
            mosi_oe  <= link_q[rirq_pkg::B_TURN]; // R15
         end else if (link_q[rirq_pkg::B_IRQMUX]) begin
            mosi_out <= irq_act ~^ irq_cfg_q[rirq_pkg::B_POL]; // R19
            mosi_oe  <= ~irq_cfg_q[rirq_pkg::B_OD]
               | ~(irq_act ~^ irq_cfg_q[rirq_pkg::B_POL]); // R19
         end else begin
            mosi_out <= 1'b0;
            mosi_oe  <= 1'b0;
         end
      end
   end

   chk_mux_selected: assert property (@(posedge pclk) disable iff (!presetn)
      ce && !spi_ss_n |=> mosi_oe == $past(link_q[7]))
      else $error("irq driven on data line while selected"); // R19

   chk_mux_off: assert property (@(posedge pclk) disable iff (!presetn)
      ce && spi_ss_n && !link_q[6] |=> !mosi_oe)
      else $error("data line driven while deselected, mux off"); // R19

endmodule // rirq_top
